// [rtl/itsc_pkg.sv]
// constants for the processor status and exception recognition unit
// assumes a single core clock; special registers are addressed by number
`default_nettype none
package itsc_pkg;
   // special register number and status field positions
   localparam logic [7:0] SR_STATUS = 8'h02;
   localparam int TIMER_BLOCK_BIT = 17;
   localparam int BLOCKED_FLAG_BIT = 14;
   localparam int TRACE_DUE_BIT = 12;
   localparam int TRACE_ARM_BIT = 13;
   localparam int ALIGN_CHECK_BIT = 11;
   localparam int STATE_HOLD_BIT = 10;
   localparam int WAIT_BIT = 7;
   localparam int PRIVILEGED_BIT = 4;
   localparam int MASK_LO_BIT = 2;
   localparam int EXT_BLOCK_BIT = 1;
   localparam int GLOBAL_BLOCK_BIT = 0;
   // implemented bits; all others read zero and ignore writes
   localparam logic [31:0] STATUS_WMASK = 32'h0002_7C9F;
   localparam logic [31:0] STATUS_RST = 32'h0000_0413;
   // fixed exception vectors
   localparam logic [7:0] VEC_UNALIGNED = 8'h01;
   localparam logic [7:0] VEC_PROT = 8'h05;
   localparam logic [7:0] VEC_TIMER = 8'h0E;
   localparam logic [7:0] VEC_TRACE = 8'h0F;
   localparam logic [7:0] VEC_IRQ0 = 8'h10;
   localparam logic [7:0] VEC_TRAP0 = 8'h14;
   localparam logic [7:0] VEC_TRAP1 = 8'h15;
   localparam int SYNC_STAGES = 4;
   localparam int NUM_IRQ = 4;
   localparam int NUM_TRAP = 2;
   typedef enum logic [1:0] {ACC_DATA, ACC_IO, ACC_INSTR} acc_kind_t;
   typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} acc_size_t;
endpackage
`default_nettype wire

// [rtl/itsc_unit.sv]
// processor status word, interrupt/trap recognition, priority and vector choice
// assumes the core pulses i_exc_ack when it takes o_exc_req and halts while o_wait is high
`default_nettype none
module itsc_unit #(
   parameter logic [7:0] VEC_WARN = 8'h10,
   parameter logic [7:0] VEC_ACC = 8'h08
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [itsc_pkg::NUM_IRQ-1:0] i_irq_n,
   input wire logic [itsc_pkg::NUM_TRAP-1:0] i_trap_n,
   input wire logic i_periph_req,
   input wire logic i_timer_req,
   input wire logic i_timer_irq_en,
   input wire logic i_warn,
   input wire logic i_acc_exc,
   input wire logic i_instr_done,
   input wire logic i_exc_ack,
   input wire logic i_sr_wr,
   input wire logic i_sr_rd,
   input wire logic [7:0] i_sr_num,
   input wire logic [31:0] i_sr_wdata,
   input wire logic i_prot_access,
   input wire logic i_dacc_valid,
   input wire itsc_pkg::acc_kind_t i_dacc_kind,
   input wire itsc_pkg::acc_size_t i_dacc_size,
   input wire logic [1:0] i_dacc_addr,
   output logic [31:0] o_sr_rdata,
   output logic o_exc_req,
   output logic [7:0] o_exc_vector,
   output logic o_wait,
   output logic o_state_hold,
   output logic o_user_mode,
   output logic o_blocked_request
);
   import itsc_pkg::*;

   localparam int NUM_IN = NUM_IRQ + NUM_TRAP;

   logic [31:0] status_r;
   logic [31:0] status_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic exc_req_r;
   logic exc_req_nxt;
   logic [7:0] exc_vec_r;
   logic [7:0] exc_vec_nxt;
   logic [NUM_IN-1:0] raw_act;
   logic [NUM_IN-1:0] act;
   logic [NUM_IRQ-1:0] act_irq;
   logic [NUM_TRAP-1:0] act_trap;
   logic [NUM_IRQ-1:0] irq_en;
   logic [1:0] mask;
   logic global_block;
   logic ext_block;
   logic privileged;
   logic periph_en;
   logic timer_ok;
   logic trace_ok;
   logic blocked_any;
   logic any_int_act;
   logic sr_hit;
   logic unal_trap;
   logic prot_trap;

   // active-low pins become active-high requests
   assign raw_act = {~i_trap_n, ~i_irq_n};

   // per-input synchroniser; recognition spans the last two stages
   genvar g;
   generate
      for (g = 0; g < NUM_IN; g++) begin : g_sync
         logic [SYNC_STAGES-1:0] sync_r;
         logic [SYNC_STAGES-1:0] sync_nxt;
         always_comb begin
            sync_nxt = {sync_r[SYNC_STAGES-2:0], raw_act[g]};
         end
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               sync_r <= '0;
            end else begin
               sync_r <= sync_nxt;
            end
         end
         assign act[g] = sync_r[SYNC_STAGES-2] | sync_r[SYNC_STAGES-1];
      end
   endgenerate

   assign act_irq = act[NUM_IRQ-1:0];
   assign act_trap = act[NUM_IN-1:NUM_IRQ];

   assign mask = status_r[MASK_LO_BIT+1:MASK_LO_BIT];
   assign global_block = status_r[GLOBAL_BLOCK_BIT];
   assign ext_block = status_r[EXT_BLOCK_BIT];
   assign privileged = status_r[PRIVILEGED_BIT];

   // mask decode: input k open when mask >= k, input 0 always open to the mask
   always_comb begin
      for (int k = 0; k < NUM_IRQ; k++) begin
         irq_en[k] = (mask >= 2'(k)) & ~ext_block & ~global_block;
      end
   end
   assign periph_en = (mask == 2'b11) & ~ext_block & ~global_block;

   assign timer_ok = i_timer_req & i_timer_irq_en & ~status_r[TIMER_BLOCK_BIT] & ~global_block;
   assign trace_ok = status_r[TRACE_DUE_BIT] & ~global_block;

   assign any_int_act = (|act_irq) | i_periph_req;
   assign blocked_any = (|(act_irq & ~irq_en)) | (i_periph_req & ~periph_en);

   // alignment applies only to external data accesses
   always_comb begin
      unal_trap = 1'b0;
      if (i_dacc_valid && i_dacc_kind == ACC_DATA && status_r[ALIGN_CHECK_BIT]) begin
         if (i_dacc_size == SZ_WORD) begin
            unal_trap = |i_dacc_addr;
         end else if (i_dacc_size == SZ_HALF) begin
            unal_trap = i_dacc_addr[0];
         end
      end
   end

   assign sr_hit = (i_sr_wr | i_sr_rd) & (i_sr_num == SR_STATUS);
   assign prot_trap = ~privileged & (i_prot_access | sr_hit);

   // exception selection by fixed priority, registered toward the core
   always_comb begin
      exc_req_nxt = 1'b1;
      exc_vec_nxt = exc_vec_r;
      if (i_warn) begin
         exc_vec_nxt = VEC_WARN;
      end else if (i_acc_exc) begin
         exc_vec_nxt = VEC_ACC;
      end else if (global_block) begin
         exc_req_nxt = 1'b0;
      end else if (unal_trap) begin
         exc_vec_nxt = VEC_UNALIGNED;
      end else if (prot_trap) begin
         exc_vec_nxt = VEC_PROT;
      end else if (act_trap[0]) begin
         exc_vec_nxt = VEC_TRAP0;
      end else if (act_trap[1]) begin
         exc_vec_nxt = VEC_TRAP1;
      end else if (trace_ok) begin
         exc_vec_nxt = VEC_TRACE;
      end else if (timer_ok) begin
         exc_vec_nxt = VEC_TIMER;
      end else begin
         exc_req_nxt = 1'b0;
         for (int k = NUM_IRQ - 1; k >= 0; k--) begin
            if (act_irq[k] && irq_en[k]) begin
               exc_req_nxt = 1'b1;
               exc_vec_nxt = VEC_IRQ0 + 8'(k);
            end
         end
         if (!(|(act_irq & irq_en)) && i_periph_req && periph_en) begin
            exc_req_nxt = 1'b1;
            exc_vec_nxt = VEC_IRQ0 + 8'(NUM_IRQ - 1);
         end
      end
   end

   // status word: software write first, hardware events override it
   always_comb begin
      status_nxt = status_r;
      if (i_sr_wr && i_sr_num == SR_STATUS && privileged) begin
         status_nxt = i_sr_wdata & STATUS_WMASK;
      end
      if (i_instr_done) begin
         status_nxt[TRACE_DUE_BIT] = status_r[TRACE_ARM_BIT];
      end
      if (blocked_any) begin
         status_nxt[BLOCKED_FLAG_BIT] = 1'b1;
      end else if (!any_int_act) begin
         status_nxt[BLOCKED_FLAG_BIT] = 1'b0;
      end
      if (i_exc_ack) begin
         status_nxt[STATE_HOLD_BIT] = 1'b1;
         status_nxt[WAIT_BIT] = 1'b0;
      end
   end

   always_comb begin
      rdata_nxt = rdata_r;
      if (i_sr_rd && i_sr_num == SR_STATUS && privileged) begin
         rdata_nxt = status_r & STATUS_WMASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         status_r <= STATUS_RST;
         rdata_r <= '0;
         exc_req_r <= 1'b0;
         exc_vec_r <= '0;
      end else begin
         status_r <= status_nxt;
         rdata_r <= rdata_nxt;
         exc_req_r <= exc_req_nxt;
         exc_vec_r <= exc_vec_nxt;
      end
   end

   assign o_sr_rdata = rdata_r;
   assign o_exc_req = exc_req_r;
   assign o_exc_vector = exc_vec_r;
   assign o_wait = status_r[WAIT_BIT];
   assign o_state_hold = status_r[STATE_HOLD_BIT];
   assign o_user_mode = ~privileged;
   assign o_blocked_request = status_r[BLOCKED_FLAG_BIT];

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_irq0_drop;
      $rose(i_irq_n[0]) ##1 i_irq_n[0] [*4];
   endsequence

   chk_timer_block: assert property ((o_exc_req && o_exc_vector == VEC_TIMER) |->
      !$past(status_r[TIMER_BLOCK_BIT]))
      else $error("timer taken while blocked");
   chk_blocked_flag: assert property (blocked_any |=> o_blocked_request)
      else $error("blocked flag not set");
   chk_trace_copy: assert property (i_instr_done |=>
      status_r[TRACE_DUE_BIT] == $past(status_r[TRACE_ARM_BIT]))
      else $error("trace due not copied");
   chk_io_align: assert property ((i_dacc_kind != ACC_DATA) |-> !unal_trap)
      else $error("alignment checked on non-data access");
   chk_hold_take: assert property (i_exc_ack |=> o_state_hold && !o_wait)
      else $error("take did not freeze or leave wait");
   chk_global_gate: assert property (o_exc_req |->
      (!$past(global_block) || $past(i_warn) || $past(i_acc_exc)))
      else $error("exception passed global block");
   chk_sync_early: assert property ($rose(act_irq[0]) |-> !$past(i_irq_n[0], 3))
      else $error("request recognised too early");
   chk_sync_drop: assert property (s_irq0_drop |-> !act_irq[0])
      else $error("recognition outlived five cycles");
   chk_trap_prio: assert property ((act_trap[0] && !global_block && !i_warn && !i_acc_exc
      && !unal_trap && !prot_trap) |=> o_exc_req && o_exc_vector == VEC_TRAP0)
      else $error("trap 0 lost priority");
   chk_irq0_mask: assert property ((act_irq[0] && !(|act_trap) && !global_block && !ext_block
      && !i_warn && !i_acc_exc && !unal_trap && !prot_trap && !trace_ok && !timer_ok)
      |=> o_exc_req && o_exc_vector == VEC_IRQ0)
      else $error("input 0 not taken");
endmodule
`default_nettype wire

// [test/req_pins.sv]
// model of the external devices that drive the interrupt and trap pins
// assumes the bench raises a request and may drop it without any ack from the handler
`default_nettype none
module req_pins (
   input wire logic [3:0] i_irq,
   input wire logic [1:0] i_trap,
   output logic [3:0] o_irq_n,
   output logic [1:0] o_trap_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // pins are pulled up, so a released request reads high
   assign o_irq_n = ~i_irq;
   assign o_trap_n = ~i_trap;
endmodule
`default_nettype wire

// [test/interrupt_trap_status_control_test.sv]
// self-checking bench for the status and exception recognition unit
// assumes the pin model req_pins and the itsc_pkg constants
`default_nettype none
module interrupt_trap_status_control_test;
   import itsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_srst = 1, z = 0, treq = 0, ten = 1, warn = 0, ack = 0, wr = 0, rd = 0, dv = 0;
   logic done = 0, per = 0, acc = 0;
   logic [7:0] num = SR_STATUS;
   logic [31:0] wd = 32'h0;
   logic [3:0] irq = 4'h0;
   logic [1:0] trap = 2'h0, addr = 2'h0;
   acc_kind_t kind = ACC_DATA;
   acc_size_t size = SZ_WORD;
   logic [31:0] rdata;
   logic [7:0] vec;
   logic req, wt, hold, user, blk;
   wire logic [3:0] irq_n;
   wire logic [1:0] trap_n;
   int fails = 0, tests_run = 0;
   req_pins u_pins (.i_irq(irq), .i_trap(trap), .o_irq_n(irq_n), .o_trap_n(trap_n));
   // warning vector value is arbitrary
   itsc_unit #(.VEC_WARN(8'h30)) u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_irq_n(irq_n), .i_trap_n(trap_n),
      .i_periph_req(per), .i_timer_req(treq), .i_timer_irq_en(ten), .i_warn(warn), .i_acc_exc(acc),
      .i_instr_done(done), .i_exc_ack(ack), .i_sr_wr(wr), .i_sr_rd(rd), .i_sr_num(num), .i_sr_wdata(wd),
      .i_prot_access(z), .i_dacc_valid(dv), .i_dacc_kind(kind), .i_dacc_size(size), .i_dacc_addr(addr),
      .o_sr_rdata(rdata), .o_exc_req(req), .o_exc_vector(vec), .o_wait(wt), .o_state_hold(hold),
      .o_user_mode(user), .o_blocked_request(blk));
   always #25 i_clk = ~i_clk;
   task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task wr_sr(input logic [31:0] v);
      @(posedge i_clk);
      wr <= 1'b1;
      wd <= v;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   task exq(input logic [7:0] v);
      cyc(6);
      chk("exc", {req, vec}, {1'b1, v});
   endtask
   task ack_it;
      @(posedge i_clk);
      ack <= 1'b1;
      @(posedge i_clk);
      ack <= 1'b0;
      #1 chk("hold", hold, 1);
   endtask
   task quiet(input string s);
      @(posedge i_clk);
      irq <= 4'h0;
      trap <= 2'h0;
      treq <= 1'b0;
      warn <= 1'b0;
      dv <= 1'b0;
      per <= 1'b0;
      acc <= 1'b0;
      done <= 1'b0;
      cyc(7);
      chk("idle", req, 0);
      $display("test %s done", s);
   endtask
   task t_reset;
      @(posedge i_clk);
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 chk("status", rdata, 32'h413);
      chk("user", {user, hold}, 2'b01);
      $display("test reset done");
   endtask
   task t_prio;
      wr_sr(32'h10);
      @(posedge i_clk);
      irq <= 4'h3;
      cyc(2);
      chk("early", req, 0);
      exq(8'h10);
      @(posedge i_clk);
      irq <= 4'h2;
      cyc(3);
      chk("linger", req, 1);
      cyc(4);
      chk("masked", {req, blk}, 2'b01);
      irq <= 4'h8;
      for (int m = 0; m < 4; m++) begin
         wr_sr(32'h10 | (m << 2));
         cyc(6);
         chk("mask", {req, blk}, (m == 3) ? 2'b11 : 2'b01);
      end
      quiet("prio");
   endtask
   task t_timer;
      wr_sr(32'h12);
      @(posedge i_clk);
      irq <= 4'h1;
      treq <= 1'b1;
      exq(VEC_TIMER);
      wr_sr(32'h20012);
      cyc(6);
      chk("tblock", {req, blk}, 2'b01);
      quiet("timer");
   endtask
   task t_trap;
      wr_sr(32'h10);
      @(posedge i_clk);
      trap <= 2'h3;
      irq <= 4'h1;
      exq(VEC_TRAP0);
      ack_it;
      quiet("trap");
   endtask
   task t_wait;
      wr_sr(32'h91);
      @(posedge i_clk);
      trap <= 2'h1;
      cyc(6);
      chk("gblock", {req, wt}, 2'b01);
      warn <= 1'b1;
      exq(8'h30);
      ack_it;
      chk("wake", wt, 0);
      quiet("wait");
   endtask
   task t_align;
      wr_sr(32'h810);
      @(posedge i_clk);
      dv <= 1'b1;
      addr <= 2'h2;
      exq(VEC_UNALIGNED);
      kind <= ACC_IO;
      cyc(3);
      chk("io", req, 0);
      kind <= ACC_DATA;
      quiet("align");
   endtask
   task t_trace;
      wr_sr(32'h2010);
      @(posedge i_clk);
      done <= 1'b1;
      @(posedge i_clk);
      done <= 1'b0;
      exq(VEC_TRACE);
      wr_sr(32'h10);
      quiet("trace");
   endtask
   task t_periph;
      wr_sr(32'h1C);
      @(posedge i_clk);
      per <= 1'b1;
      exq(8'h13);
      wr_sr(32'h18);
      cyc(2);
      chk("pmask", {req, blk}, 2'b01);
      quiet("periph");
   endtask
   task t_user;
      wr_sr(32'h0);
      cyc(1);
      chk("user", user, 1);
      @(posedge i_clk);
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 chk("prot", {req, vec}, {1'b1, VEC_PROT});
      chk("rd kept", rdata, 32'h413);
      acc <= 1'b1;
      exq(8'h08);
      quiet("user");
      @(posedge i_clk);
      i_srst <= 1'b1;
      cyc(5);
      i_srst <= 1'b0;
      cyc(2);
      chk("rst", {user, hold, req}, 3'b010);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge i_clk);
      i_srst <= 1'b0;
      t_reset;
      t_prio;
      t_timer;
      t_trap;
      t_wait;
      t_align;
      t_trace;
      t_periph;
      t_user;
      give_verdict;
   end
   initial begin
      #400000;
      fails++;
      give_verdict;
   end
endmodule
`default_nettype wire
